/* src/dcp_pkg.sv */
package dcp_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_PWM_PERIOD = 8'h5c;
	localparam logic [7:0] IDX_SWITCHING_DELAY = 8'h5d;
	localparam logic [7:0] IDX_PULSE_WIDTH = 8'h5e;

	// field positions of the switching-delay and period registers
	localparam int CAL_BIT = 7;
	localparam int POL_BIT = 5;
	localparam int PERIOD_FIXED_BIT = 6;

	// reset values
	localparam logic [7:0] PERIOD_RST = 8'hff;
	localparam logic [4:0] MIN_OFF_RST = 5'h14;

	// timing: one step is 61.035 ns, clock period 10 ns, both in ps
	localparam int STEP_PS = 61035;
	localparam int CLK_PS = 10000;
	localparam logic [7:0] OFF_EXTRA = 8'h04;
	localparam int CAL_STEPS_DEFAULT = 1024;

	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {
		DCP_MODE_RUN = 2'b01,
		DCP_MODE_CAL = 2'b10
	} dcp_mode_t;

	// whole state of the block
	typedef struct packed {
		logic aw_got;
		logic [7:0] aw_idx;
		logic w_got;
		logic [7:0] w_data;
		logic w_lane0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [7:0] rdata;
		logic [7:0] period;
		logic [4:0] min_off;
		dcp_mode_t mode;
		logic [15:0] cal_cnt;
		logic [16:0] acc;
		logic [7:0] step_cnt;
		logic [7:0] on_steps;
		logic [7:0] pulse_width;
		logic drive;
	} dcp_state_t;
endpackage : dcp_pkg

/* src/dcp_pwm_control.sv */
// Operation
// - period equals count times 61.035 ns
// - period bit 6 reads one, ignores writes
// - writing calibration bit one starts calibration
// - calibration bit reads one while running
// - polarity bit read-only, shows feed-forward relation
// - minimum off time is field plus four steps
// - pulse width readback minus off-field minus four
`timescale 1ns/100ps
module dcp_pwm_control #(
	parameter logic FF_SAME_POLARITY = 1'b0,
	parameter logic [15:0] CAL_STEPS = 16'(dcp_pkg::CAL_STEPS_DEFAULT)
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [7:0] on_request,
	output logic step_tick,
	output logic converter_drive_out,
	output logic feedforward_out
);

	// the accumulator works in ps so the odd step length needs no divider
	// with an integer ratio; the price is one clock of jitter per step
	localparam logic [16:0] STEP_ACC = 17'(dcp_pkg::STEP_PS);
	localparam logic [16:0] CLK_ACC = 17'(dcp_pkg::CLK_PS);

	dcp_pkg::dcp_state_t s_q;
	dcp_pkg::dcp_state_t s_d;
	logic [16:0] acc_sum;
	logic tick;
	logic [7:0] next_cnt;
	logic [7:0] off_steps;
	logic [7:0] on_room;
	logic [7:0] on_next;
	logic [7:0] delay_reg;
	logic wr_do;
	logic rd_do;
	logic [7:0] rd_idx;

	// step enable: fractional accumulator keeps the 61.035 ns average exact
	assign acc_sum = s_q.acc + CLK_ACC;
	assign tick = (acc_sum >= STEP_ACC);

	// off time and room left for the on part of a period
	assign off_steps = 8'(s_q.min_off) + dcp_pkg::OFF_EXTRA;
	assign on_room = s_q.period - off_steps;
	assign on_next = (on_request > on_room) ? on_room : on_request;

	// switching-delay readback; bit 6 reserved as zero
	always_comb begin
		delay_reg = 8'h00;
		delay_reg[dcp_pkg::CAL_BIT] = (s_q.mode == dcp_pkg::DCP_MODE_CAL);
		delay_reg[dcp_pkg::POL_BIT] = FF_SAME_POLARITY;
		delay_reg[4:0] = s_q.min_off;
	end

	// a write is answered one cycle after both halves are held; this costs
	// a cycle but keeps the register decode off the ready paths
	// handshake outputs straight from state
	assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
	assign s_axi_wready = !s_q.w_got && !s_q.bvalid;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_arready = !s_q.rvalid;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rresp = s_q.rresp;
	assign s_axi_rdata = {24'h00_0000, s_q.rdata};
	assign wr_do = s_q.aw_got && s_q.w_got && !s_q.bvalid;
	assign rd_do = s_axi_arvalid && !s_q.rvalid;
	assign rd_idx = s_axi_araddr[9:2];

	// feed-forward is formed from the registered drive, so it cannot glitch
	// pins: feed-forward follows drive, inverted unless same polarity
	assign converter_drive_out = s_q.drive;
	assign feedforward_out = s_q.drive ^ ~FF_SAME_POLARITY;
	assign step_tick = tick;

	// next state of everything
	always_comb begin
		s_d = s_q;
		next_cnt = 8'h00;

		// write channels: address and data taken in either order
		if (s_axi_awvalid && s_axi_awready) begin
			s_d.aw_got = 1'b1;
			s_d.aw_idx = s_axi_awaddr[9:2];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_d.w_got = 1'b1;
			s_d.w_data = s_axi_wdata[7:0];
			s_d.w_lane0 = s_axi_wstrb[0];
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end

		// limitation: a shorter period written mid-period ends the current one
		// at the new length, or at the next step if the count is already past it, so that one off time is not protected
		// step counter and pwm; new width only at the period edge
		if (tick) begin
			s_d.acc = acc_sum - STEP_ACC;
			if (s_q.step_cnt + 8'h01 >= s_q.period) begin
				next_cnt = 8'h00;
				s_d.on_steps = on_next;
				s_d.pulse_width = on_next + off_steps;
			end else begin
				next_cnt = s_q.step_cnt + 8'h01;
			end
			s_d.step_cnt = next_cnt;
			s_d.drive = (s_q.mode == dcp_pkg::DCP_MODE_RUN)
				&& (next_cnt < s_d.on_steps);
		end else begin
			s_d.acc = acc_sum;
		end

		// calibration run; drive drops at the next step and stays off,
		// so the gate only ever moves on a step boundary
		case (s_q.mode)
			dcp_pkg::DCP_MODE_RUN: begin
			end
			dcp_pkg::DCP_MODE_CAL: begin
				if (tick) begin
					if (s_q.cal_cnt == 16'h0000) begin
						s_d.mode = dcp_pkg::DCP_MODE_RUN;
					end else begin
						s_d.cal_cnt = s_q.cal_cnt - 16'h0001;
					end
				end
			end
			default: begin
				s_d.mode = dcp_pkg::DCP_MODE_RUN;
			end
		endcase

		// register write once both halves are in
		if (wr_do) begin
			s_d.aw_got = 1'b0;
			s_d.w_got = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = dcp_pkg::RESP_OKAY;
			case (s_q.aw_idx)
				dcp_pkg::IDX_PWM_PERIOD: begin
					if (s_q.w_lane0) begin
						s_d.period = s_q.w_data;
						s_d.period[dcp_pkg::PERIOD_FIXED_BIT] = 1'b1;
					end
				end
				dcp_pkg::IDX_SWITCHING_DELAY: begin
					if (s_q.w_lane0) begin
						s_d.min_off = s_q.w_data[4:0];
						// a second start while running is ignored
						if (s_q.w_data[dcp_pkg::CAL_BIT]
							&& s_q.mode == dcp_pkg::DCP_MODE_RUN) begin
							s_d.mode = dcp_pkg::DCP_MODE_CAL;
							s_d.cal_cnt = CAL_STEPS - 16'h0001;
						end
					end
				end
				dcp_pkg::IDX_PULSE_WIDTH: begin
				end
				default: begin
					s_d.bresp = dcp_pkg::RESP_SLVERR;
				end
			endcase
		end

		// bits 31:8 always read zero; only lane 0 carries a register
		// register read, answered one cycle after address taken
		if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end
		if (rd_do) begin
			s_d.rvalid = 1'b1;
			s_d.rresp = dcp_pkg::RESP_OKAY;
			case (rd_idx)
				dcp_pkg::IDX_PWM_PERIOD: begin
					s_d.rdata = s_q.period;
				end
				dcp_pkg::IDX_SWITCHING_DELAY: begin
					s_d.rdata = delay_reg;
				end
				dcp_pkg::IDX_PULSE_WIDTH: begin
					s_d.rdata = s_q.pulse_width;
				end
				default: begin
					s_d.rdata = 8'h00;
					s_d.rresp = dcp_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	// reset values come from the package so bench and logic agree
	// single state register, synchronous reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
			s_q.period <= dcp_pkg::PERIOD_RST;
			s_q.min_off <= dcp_pkg::MIN_OFF_RST;
			s_q.mode <= dcp_pkg::DCP_MODE_RUN;
			s_q.pulse_width <= dcp_pkg::OFF_EXTRA + 8'(dcp_pkg::MIN_OFF_RST);
		end else begin
			s_q <= s_d;
		end
	end

endmodule : dcp_pwm_control

/* test/dcp_pwm_props.sv */
`timescale 1ns/100ps
module dcp_pwm_props #(
	parameter logic FF_SAME_POLARITY = 1'b0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic step_tick,
	input wire logic converter_drive_out,
	input wire logic feedforward_out
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// steps average 6.1 cycles, so gaps are 6 or 7
	a_tick_gap: assert property (step_tick |=> !step_tick [*5])
		else $error("step gap too short");
	a_tick_due: assert property (step_tick |-> ##[6:7] step_tick)
		else $error("step gap too long");
	a_drive_step: assert property (
		$changed(converter_drive_out) |-> $past(step_tick))
		else $error("drive moved off a step");
	// at least four steps low, each step six cycles or more
	a_min_off: assert property (
		$fell(converter_drive_out) |-> ##23 !converter_drive_out)
		else $error("off time too short");
	a_ff_polarity: assert property (
		feedforward_out == (converter_drive_out ^ !FF_SAME_POLARITY))
		else $error("feed-forward polarity wrong");
	// both halves are held one cycle before the answer is raised
	a_wr_resp: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
		else $error("write answer late");
	a_rd_resp: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid && s_axi_rdata[31:8] == 24'h00_0000)
		else $error("read answer late or wide");
	a_wr_block: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
	a_rd_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	c_drive: cover property ($rose(converter_drive_out));
	c_write: cover property (s_axi_bvalid);
	c_read: cover property (s_axi_rvalid);
endmodule : dcp_pwm_props

bind dcp_pwm_control dcp_pwm_props #(
	.FF_SAME_POLARITY(FF_SAME_POLARITY)
) u_props (
	.aclk(aclk),
	.aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid),
	.step_tick(step_tick),
	.converter_drive_out(converter_drive_out),
	.feedforward_out(feedforward_out)
);

/* test/dcp_switch_model.sv */
`timescale 1ns/100ps
// switch gate: measures on time and period in whole steps
module dcp_switch_model (
	input wire logic aclk,
	input wire logic tick,
	input wire logic drive,
	output logic [7:0] on_len,
	output logic [7:0] per_len
);
	logic [7:0] on_cnt;
	logic [7:0] per_cnt;
	logic drive_q;
	// counts latch on the gate edges, so one period of lag
	always @(posedge aclk) begin
		drive_q <= drive;
		on_cnt <= drive ? on_cnt + tick : 8'h00;
		if (!drive && drive_q) on_len <= on_cnt;
		per_cnt <= (drive && !drive_q) ? 8'(tick) : per_cnt + tick;
		if (drive && !drive_q) per_len <= per_cnt;
	end
endmodule : dcp_switch_model

/* test/tb_dcdc_converter_pwm_control.sv */
`timescale 1ns/100ps
module tb_dcdc_converter_pwm_control;
	localparam logic [7:0] P = dcp_pkg::IDX_PWM_PERIOD;
	localparam logic [7:0] D = dcp_pkg::IDX_SWITCHING_DELAY;
	localparam logic [7:0] W = dcp_pkg::IDX_PULSE_WIDTH;
	localparam logic [1:0] OK = dcp_pkg::RESP_OKAY;
	localparam logic [1:0] ER = dcp_pkg::RESP_SLVERR;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, step_tick;
	logic converter_drive_out, feedforward_out;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [7:0] on_request, on_len, per_len;
	int err_total = 0, n_compared = 0, cyc = 0;
	// short calibration keeps the run brief
	dcp_pwm_control #(.CAL_STEPS(16'h0004)) uut (.*);
	dcp_switch_model sw (.aclk, .tick(step_tick),
		.drive(converter_drive_out), .on_len, .per_len);
	always #5 aclk = ~aclk;
	// hang guard, well above two long periods
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			test_done;
		end
	end
	task test_done;
		if (err_total == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : test_done
	task chk(input [31:0] s, input [31:0] e);
		n_compared++;
		if (s !== e) begin
			err_total++;
			$display("MISMATCH %0t %h %h", $time, s, e);
		end
	endtask : chk
	// valids drop once taken; bready stays up until the answer
	task wr(input [7:0] i, input [7:0] d, input [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= {2'h0, i, 2'h0};
		s_axi_wdata <= {24'h00_0000, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, r);
	endtask : wr
	task rd(input [7:0] i, input [31:0] e, input [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= {2'h0, i, 2'h0};
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, e);
		chk(s_axi_rresp, r);
	endtask : rd
	// second pulse is sure to carry the latest settings
	task pulses;
		repeat (2) @(negedge converter_drive_out);
		repeat (2) @(posedge aclk);
	endtask : pulses
	initial begin
		{aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'hf;
		on_request = 8'hff;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rd(P, 8'hff, OK);
		rd(D, 8'h14, OK);
		rd(W, 8'h18, OK);
		wr(P, 8'h00, OK);
		rd(P, 8'h40, OK);
		wr(P, 8'h10, OK);
		rd(P, 8'h50, OK);
		wr(D, 8'h02, OK);
		rd(D, 8'h02, OK);
		// full request is clamped to 80 - (2 + 4) steps
		pulses;
		chk(on_len, 8'h4a);
		chk(converter_drive_out, 32'h0000_0000);
		chk(feedforward_out, 32'h0000_0001);
		rd(W, 8'h50, OK);
		on_request <= 8'h10;
		pulses;
		chk(on_len, 8'h10);
		chk(per_len, 8'h50);
		rd(W, 8'h16, OK);
		wr(W, 8'h00, OK);
		rd(W, 8'h16, OK);
		wr(8'h10, 8'h55, ER);
		rd(8'h10, 8'h00, ER);
		wr(D, 8'h7f, OK);
		rd(D, 8'h1f, OK);
		wr(D, 8'h9f, OK);
		rd(D, 8'h9f, OK);
		repeat (100) @(posedge aclk);
		rd(D, 8'h1f, OK);
		test_done;
	end
endmodule : tb_dcdc_converter_pwm_control
